// file: common/smc_cfg.svh
// Constants for the segment and mode control block
//
// Summary of operation
// [R01] Six 16-bit selector registers name the segments the program can address.
// [R02] Protected segments may span one byte up to the full 4 Gbyte range.
// [R03] Real-mode segments always have a fixed 64 Kbyte size; the code keeps a protected-mode limit until the selector is reloaded.
// [R04] Fetches use the code selector, stack references the stack selector.
// [R05] Each selector owns a hidden cache of base, limit and attributes.
// [R06] Writing a selector refreshes its hidden cache entry automatically.
// [R07] Real-mode load sets only base, selector shifted left four bits; the code also reloads the fixed real limit and attributes.
// [R08] Protected load fills base, limit and attributes from the indexed descriptor.
// [R09] Every reference adds the cached 32-bit base into the linear address.
// [R10] Every reference compares its offset against the cached limit.
// [R11] Every reference checks cached attributes against the access kind.
// [R12] Control register access is allowed only at privilege level 0.
// [R13] The main control register holds ten defined control and status bits.
// [R14] Paging and protection both clear selects real mode.
// [R15] Protection set without paging selects protected mode, default size from code.
// [R16] Paging set with protection clear raises a protection fault, code 0.
// [R17] Paging and protection both set selects paged protected operation.
// [R18] Fill-disable and write-through-disable set: no fills, write-throughs, invalidates.
// [R19] Fill-disable set alone: no fills, write-through and invalidates stay active.
// [R20] Fill-disable clear with write-through-disable set raises a protection fault.
// [R21] Both cache bits clear: fills, write-through and invalidates all active.
// [R22] Fill-disable bit is one after reset.
// [R23] Numeric error select bit is zero after reset.
// [R24] Illegal control values fault and leave the old contents unchanged.
// [R25] Mode and cache decodes follow the committed control register value.
`ifndef SMC_CFG_SVH
`define SMC_CFG_SVH
// ***************************************
// Register map
// ***************************************
`define SMC_ADR_CTRL 8'h18
`define SMC_ADR_STAT 8'h1c
// ***************************************
// Control register layout
// ***************************************
`define SMC_B_PAGING 31
`define SMC_B_FILLDIS 30
`define SMC_B_WTDIS 29
`define SMC_B_PROT 0
`define SMC_CTRL_MASK 32'he005_002f
`define SMC_CTRL_RST 32'h4000_0000
`define SMC_FLT_CODE 16'h0000
// ***************************************
// Segment cache
// ***************************************
`define SMC_NSEG 6
`define SMC_SEG_CODE 3'h0
`define SMC_SEG_STACK 3'h1
`define SMC_REAL_SHIFT 4
`define SMC_REAL_LIMIT 32'h0000_ffff
`define SMC_REAL_ATTR 8'h0f
`define SMC_A_P 0
`define SMC_A_R 1
`define SMC_A_W 2
`define SMC_A_X 3
`define SMC_A_D 4
`endif

// file: common/smc_pkg.sv
// Types shared by the segment and mode control block
package smc_pkg;
   typedef enum logic [1:0] {SMC_REAL, SMC_PROT, SMC_PAGED} smc_mode_t;
   typedef enum logic [2:0] {SMC_RD, SMC_WR, SMC_FETCH, SMC_STK_RD, SMC_STK_WR} smc_acc_t;
   typedef struct packed {
      logic [31:0] base;
      logic [31:0] limit;
      logic [7:0] attr;
   } smc_desc_t;
   typedef struct packed {
      logic valid;
      smc_acc_t kind;
      logic [2:0] seg;
      logic [31:0] offset;
   } smc_req_t;
   typedef struct packed {
      logic valid;
      logic [31:0] lin;
      logic limit_flt;
      logic attr_flt;
   } smc_res_t;
endpackage : smc_pkg

// file: rtl/smc_core.sv
// Segment selectors, descriptor caches and control register mode decode
`timescale 1ns/1ps
`include "smc_cfg.svh"
module smc_core import smc_pkg::*; (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_ce,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [1:0] i_cpl,
   input wire smc_desc_t i_desc,
   input wire smc_req_t i_req,
   output logic [31:0] o_rdata,
   output smc_res_t o_res,
   output logic o_prot_fault,
   output logic [15:0] o_fault_code,
   output smc_mode_t o_mode,
   output logic o_fill_en,
   output logic o_wt_en,
   output logic o_def32
);

   // ***************************************
   // Functions
   // ***************************************
   function automatic logic ctrl_ok(input logic [31:0] v);
      ctrl_ok = !(v[`SMC_B_PAGING] && !v[`SMC_B_PROT]) && // R16
                !(!v[`SMC_B_FILLDIS] && v[`SMC_B_WTDIS]); // R20
   endfunction : ctrl_ok

   // Fetch and stack kinds ignore the requested segment field
   function automatic logic [2:0] ref_seg(input smc_req_t r);
      case (r.kind)
         SMC_FETCH: ref_seg = `SMC_SEG_CODE; // R04
         SMC_STK_RD, SMC_STK_WR: ref_seg = `SMC_SEG_STACK; // R04
         default: ref_seg = r.seg;
      endcase
   endfunction : ref_seg

   function automatic logic attr_bad(input logic [7:0] a, input smc_acc_t k);
      case (k)
         SMC_FETCH: attr_bad = !a[`SMC_A_P] || !a[`SMC_A_X];
         SMC_WR, SMC_STK_WR: attr_bad = !a[`SMC_A_P] || !a[`SMC_A_W];
         default: attr_bad = !a[`SMC_A_P] || !a[`SMC_A_R];
      endcase
   endfunction : attr_bad

   // ***************************************
   // State
   // ***************************************
   logic [15:0] sel_r [`SMC_NSEG];
   smc_desc_t cache_r [`SMC_NSEG];
   logic [31:0] ctrl_r;
   logic flt_seen_r;
   logic [31:0] rdata_r;
   smc_res_t res_r;
   logic flt_r;
   logic [15:0] code_r;
   smc_mode_t mode_r;
   logic fill_r;
   logic wt_r;
   logic def32_r;

   logic [2:0] wr_idx;
   logic sel_wr;
   logic ctl_wr;
   logic ctl_bad;
   logic stat_wr;
   logic prot;
   logic [2:0] rseg;
   smc_desc_t rdesc;

   assign wr_idx = i_addr[4:2];
   assign sel_wr = i_ce && i_wr && i_addr < `SMC_ADR_CTRL && i_addr[1:0] == 2'h0;
   assign ctl_wr = i_ce && i_wr && i_addr == `SMC_ADR_CTRL;
   // Privilege gate shares the fault path with illegal pairs
   assign ctl_bad = !ctrl_ok(i_wdata) || i_cpl != 2'h0; // R12
   assign stat_wr = i_ce && i_wr && i_addr == `SMC_ADR_STAT;
   assign prot = ctrl_r[`SMC_B_PROT];
   assign rseg = ref_seg(i_req);
   assign rdesc = cache_r[rseg];

   // ***************************************
   // Selectors and hidden caches
   // ***************************************
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         for (int i = 0; i < `SMC_NSEG; i++) begin
            sel_r[i] <= 16'h0000;
         end
      end else if (sel_wr) begin
         sel_r[wr_idx] <= i_wdata[15:0]; // R01
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         for (int i = 0; i < `SMC_NSEG; i++) begin
            cache_r[i].base <= 32'h0000_0000;
            cache_r[i].limit <= `SMC_REAL_LIMIT;
            cache_r[i].attr <= `SMC_REAL_ATTR;
         end
      end else if (sel_wr) begin // R06
         if (prot) begin
            // Descriptor lookup is done outside; full 32-bit limit allowed
            cache_r[wr_idx] <= i_desc; // R08 R02 R05
         end else begin
            cache_r[wr_idx].base <= {12'h000, i_wdata[15:0], 4'h0}; // R07
            // Each real-mode selector load restores the fixed real limits
            cache_r[wr_idx].limit <= `SMC_REAL_LIMIT; // R03
            cache_r[wr_idx].attr <= `SMC_REAL_ATTR;
         end
      end
   end

   // ***************************************
   // Control register
   // ***************************************
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ctrl_r <= `SMC_CTRL_RST; // R22 R23
      end else if (ctl_wr && !ctl_bad) begin
         ctrl_r <= i_wdata & `SMC_CTRL_MASK; // R13 R24
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         flt_r <= 1'b0;
      end else if (i_ce) begin
         flt_r <= ctl_wr && ctl_bad; // R16 R20
      end
   end

   // Code kept in a flop so every output leaves a register
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         code_r <= `SMC_FLT_CODE;
      end else if (i_ce) begin
         code_r <= `SMC_FLT_CODE; // R16
      end
   end

   // Set wins over a same-cycle write-one clear
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         flt_seen_r <= 1'b0;
      end else if (ctl_wr && ctl_bad) begin
         flt_seen_r <= 1'b1;
      end else if (stat_wr && i_wdata[0]) begin
         flt_seen_r <= 1'b0;
      end
   end

   // ***************************************
   // Mode and cache policy decode
   // ***************************************
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         mode_r <= SMC_REAL;
         fill_r <= 1'b0;
         wt_r <= 1'b1;
         def32_r <= 1'b0;
      end else if (i_ce) begin
         // Decoded from the committed value only, never the bus word
         case ({ctrl_r[`SMC_B_PAGING], prot}) // R25
            2'b01: mode_r <= SMC_PROT; // R15
            2'b11: mode_r <= SMC_PAGED; // R17
            default: mode_r <= SMC_REAL; // R14
         endcase
         fill_r <= !ctrl_r[`SMC_B_FILLDIS]; // R18 R19 R21
         wt_r <= !ctrl_r[`SMC_B_WTDIS]; // R18 R19 R21
         def32_r <= prot && cache_r[`SMC_SEG_CODE].attr[`SMC_A_D]; // R15
      end
   end

   // ***************************************
   // Memory reference path
   // ***************************************
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         res_r <= '0;
      end else if (i_ce) begin
         res_r.valid <= i_req.valid;
         res_r.lin <= rdesc.base + i_req.offset; // R09
         res_r.limit_flt <= i_req.valid && i_req.offset > rdesc.limit; // R10
         res_r.attr_flt <= i_req.valid && attr_bad(rdesc.attr, i_req.kind); // R11
      end
   end

   // ***************************************
   // Register read port
   // ***************************************
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rdata_r <= 32'h0000_0000;
      end else if (i_ce) begin
         rdata_r <= 32'h0000_0000;
         if (i_rd) begin
            if (i_addr < `SMC_ADR_CTRL && i_addr[1:0] == 2'h0) begin
               rdata_r <= {16'h0000, sel_r[wr_idx]};
            end else if (i_addr == `SMC_ADR_CTRL && i_cpl == 2'h0) begin
               rdata_r <= ctrl_r; // R12
            end else if (i_addr == `SMC_ADR_STAT) begin
               rdata_r <= {27'h0, wt_r, fill_r, mode_r, flt_seen_r};
            end
         end
      end
   end

   assign o_rdata = rdata_r;
   assign o_res = res_r;
   assign o_prot_fault = flt_r;
   assign o_fault_code = code_r;
   assign o_mode = mode_r;
   assign o_fill_en = fill_r;
   assign o_wt_en = wt_r;
   assign o_def32 = def32_r;

   // ***************************************
   // Assertions
   // ***************************************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_arst_n);

   property p_ctrl_legal;
      ctrl_ok(ctrl_r);
   endproperty
   a_ctrl_legal: assert property (p_ctrl_legal) // R24
      else $error("illegal control value committed");

   property p_paging_fault;
      ctl_wr && i_wdata[`SMC_B_PAGING] && !i_wdata[`SMC_B_PROT]
         |=> o_prot_fault && o_fault_code == `SMC_FLT_CODE && $stable(ctrl_r);
   endproperty
   a_paging_fault: assert property (p_paging_fault) // R16
      else $error("paging without protection not faulted");

   property p_wt_fault;
      ctl_wr && !i_wdata[`SMC_B_FILLDIS] && i_wdata[`SMC_B_WTDIS]
         |=> o_prot_fault && $stable(ctrl_r);
   endproperty
   a_wt_fault: assert property (p_wt_fault) // R20
      else $error("bad cache pair not faulted");

   property p_priv;
      ctl_wr && i_cpl != 2'h0 |=> o_prot_fault && $stable(ctrl_r);
   endproperty
   a_priv: assert property (p_priv) // R12
      else $error("control write above level 0 accepted");

   property p_real_load;
      sel_wr && !prot |=> cache_r[$past(wr_idx)].base == {12'h000, $past(i_wdata[15:0]), 4'h0}
         && cache_r[$past(wr_idx)].limit == `SMC_REAL_LIMIT;
   endproperty
   a_real_load: assert property (p_real_load) // R07
      else $error("real load base or limit wrong");

   property p_prot_load;
      sel_wr && prot |=> cache_r[$past(wr_idx)] == $past(i_desc);
   endproperty
   a_prot_load: assert property (p_prot_load) // R08
      else $error("protected load did not copy descriptor");

   property p_lin;
      i_ce && i_req.valid |=> o_res.valid && o_res.lin == $past(rdesc.base) + $past(i_req.offset);
   endproperty
   a_lin: assert property (p_lin) // R09
      else $error("linear address wrong");

   property p_limit;
      i_ce && i_req.valid |=> o_res.limit_flt == ($past(i_req.offset) > $past(rdesc.limit));
   endproperty
   a_limit: assert property (p_limit) // R10
      else $error("limit check wrong");

   property p_paged;
      i_ce && ctrl_r[`SMC_B_PAGING] && ctrl_r[`SMC_B_PROT] |=> o_mode == SMC_PAGED;
   endproperty
   a_paged: assert property (p_paged) // R17
      else $error("paged mode not decoded");

   property p_fill;
      i_ce && ctrl_r[`SMC_B_FILLDIS] |=> !o_fill_en;
   endproperty
   a_fill: assert property (p_fill) // R18
      else $error("fills enabled while disabled");

   property p_real_mode;
      i_ce && !ctrl_r[`SMC_B_PAGING] && !prot |=> o_mode == SMC_REAL;
   endproperty
   a_real_mode: assert property (p_real_mode) // R14
      else $error("real mode not decoded");

   property p_prot_mode;
      i_ce && !ctrl_r[`SMC_B_PAGING] && prot |=> o_mode == SMC_PROT;
   endproperty
   a_prot_mode: assert property (p_prot_mode) // R15
      else $error("protected mode not decoded");

   property p_wt;
      i_ce |=> o_wt_en != $past(ctrl_r[`SMC_B_WTDIS]);
   endproperty
   a_wt: assert property (p_wt) // R19
      else $error("write-through enable does not follow control");

   property p_fill_on;
      i_ce && !ctrl_r[`SMC_B_FILLDIS] |=> o_fill_en;
   endproperty
   a_fill_on: assert property (p_fill_on) // R21
      else $error("fills disabled while allowed");

   property p_rd_attr;
      i_ce && i_req.valid && i_req.kind == SMC_RD && !rdesc.attr[`SMC_A_R]
         |=> o_res.attr_flt;
   endproperty
   a_rd_attr: assert property (p_rd_attr) // R11
      else $error("read of unreadable segment not flagged");

   property p_stack;
      i_ce && i_req.valid && (i_req.kind == SMC_STK_RD || i_req.kind == SMC_STK_WR)
         |=> o_res.lin == $past(cache_r[`SMC_SEG_STACK].base) + $past(i_req.offset);
   endproperty
   a_stack: assert property (p_stack) // R04
      else $error("stack reference not based on stack segment");

   property p_mask;
      (ctrl_r & ~`SMC_CTRL_MASK) == 32'h0000_0000;
   endproperty
   a_mask: assert property (p_mask) // R13
      else $error("undefined control bit set");

   property p_sel_load;
      sel_wr |=> sel_r[$past(wr_idx)] == $past(i_wdata[15:0]);
   endproperty
   a_sel_load: assert property (p_sel_load) // R06
      else $error("selector write lost");

   property p_ctrl_commit;
      ctl_wr && !ctl_bad |=> !o_prot_fault && ctrl_r == $past(i_wdata & `SMC_CTRL_MASK);
   endproperty
   a_ctrl_commit: assert property (p_ctrl_commit) // R24
      else $error("legal control value not committed");

   property p_priv_read;
      i_ce && i_rd && i_addr == `SMC_ADR_CTRL && i_cpl != 2'h0
         |=> o_rdata == 32'h0000_0000;
   endproperty
   a_priv_read: assert property (p_priv_read) // R12
      else $error("control read above level 0 returned data");

   c_real_load: cover property (sel_wr && !prot);
   c_prot_load: cover property (sel_wr && prot);
   c_fault: cover property (o_prot_fault);
   c_paged: cover property (o_mode == SMC_PAGED);
   c_fill_on: cover property (o_fill_en);

endmodule : smc_core

// file: tb/tb_top.sv
// Self-checking bench for the segment and mode control block
`timescale 1ns/1ps
`include "smc_cfg.svh"
module tb_top import smc_pkg::*; ;
   // ***************************************
   // Stimulus and observed signals
   // ***************************************
   logic i_clk = 1'b0;
   logic i_arst_n = 1'b0;
   logic i_ce = 1'b1;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [7:0] i_addr = 8'h00;
   logic [31:0] i_wdata = 32'h0;
   logic [1:0] i_cpl = 2'h0;
   smc_desc_t dsc = '0;
   smc_req_t i_req = '0;
   logic [31:0] o_rdata;
   smc_res_t o_res;
   logic o_prot_fault;
   logic [15:0] o_fault_code;
   smc_mode_t o_mode;
   logic o_fill_en;
   logic o_wt_en;
   logic o_def32;
   logic [31:0] rd;
   logic flt;
   smc_res_t res;
   int n_errors = 0;
   int n_compared = 0;
   // Illegal control pairs, then legal values with expected decode
   logic [31:0] bad[2] = '{32'h8000_0000, 32'h2000_0000};
   logic [31:0] cv[5] = '{32'h6000_0000, 32'h4000_0001, 32'hffff_ffff, 32'h0, 32'h1};
   logic [3:0] mx[5] = '{{SMC_REAL, 2'b00}, {SMC_PROT, 2'b01}, {SMC_PAGED, 2'b00},
      {SMC_REAL, 2'b11}, {SMC_PROT, 2'b11}};

   always #20 i_clk = ~i_clk;

   smc_core DUT (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_ce(i_ce),
      .i_addr(i_addr),
      .i_wdata(i_wdata),
      .i_wr(i_wr),
      .i_rd(i_rd),
      .i_cpl(i_cpl),
      .i_desc(dsc),
      .i_req(i_req),
      .o_rdata(o_rdata),
      .o_res(o_res),
      .o_prot_fault(o_prot_fault),
      .o_fault_code(o_fault_code),
      .o_mode(o_mode),
      .o_fill_en(o_fill_en),
      .o_wt_en(o_wt_en),
      .o_def32(o_def32)
   );

   // ***************************************
   // Access tasks
   // ***************************************
   task chk(input logic [39:0] g, input logic [39:0] e);
      n_compared++;
      if (g !== e) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
         n_errors++;
      end
   endtask : chk

   // Read data and fault pulse both stand only in the cycle after the strobe
   task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_wr <= w;
      i_rd <= !w;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
      i_rd <= 1'b0;
      #1;
      rd = o_rdata;
      flt = o_prot_fault;
   endtask : acc

   task req(input smc_acc_t k, input logic [2:0] s, input logic [31:0] off);
      @(posedge i_clk);
      i_req <= '{1'b1, k, s, off};
      @(posedge i_clk);
      i_req <= '0;
      #1;
      res = o_res;
   endtask : req

   // Decodes lag the committed value by one cycle
   task tick;
      @(posedge i_clk);
      #1;
   endtask : tick

   task wrap_up;
      if (n_errors == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : wrap_up

   // ***************************************
   // Main sequence
   // ***************************************
   initial begin
      repeat (10) @(posedge i_clk);
      i_arst_n <= 1'b1;
      tick();
      chk({o_mode, o_fill_en, o_wt_en, o_def32}, {SMC_REAL, 3'b010});
      acc(1'b0, `SMC_ADR_CTRL, 32'h0);
      chk(rd, 32'h4000_0000);
      acc(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0);
      // Real mode: base is selector times sixteen, fixed 64 Kbyte limit
      acc(1'b1, 8'h00, 32'hffff_1234);
      acc(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0000_1234);
      req(SMC_FETCH, 3'h5, 32'h10);
      chk(res.valid, 1'b1);
      chk({res.lin, res.limit_flt, res.attr_flt}, {32'h0001_2350, 2'b00});
      req(SMC_RD, 3'h0, 32'hffff);
      chk(res.limit_flt, 1'b0);
      req(SMC_RD, 3'h0, 32'h0001_0000);
      chk(res.limit_flt, 1'b1);
      foreach (bad[i]) begin
         acc(1'b1, `SMC_ADR_CTRL, bad[i]);
         chk({flt, o_fault_code}, 17'h10000);
         acc(1'b0, `SMC_ADR_CTRL, 32'h0);
         chk(rd, 32'h4000_0000);
      end
      // Sticky fault flag in status, cleared by writing one
      acc(1'b0, `SMC_ADR_STAT, 32'h0);
      chk(rd, 32'h0000_0011);
      acc(1'b1, `SMC_ADR_STAT, 32'h1);
      acc(1'b0, `SMC_ADR_STAT, 32'h0);
      chk(rd, 32'h0000_0010);
      @(posedge i_clk) i_cpl <= 2'h1;
      acc(1'b1, `SMC_ADR_CTRL, 32'h1);
      chk(flt, 1'b1);
      acc(1'b0, `SMC_ADR_CTRL, 32'h0);
      chk(rd, 32'h0);
      @(posedge i_clk) i_cpl <= 2'h0;
      acc(1'b0, `SMC_ADR_CTRL, 32'h0);
      chk(rd, 32'h4000_0000);
      // Every legal mode and cache pair; the last one ends in protected mode
      foreach (cv[i]) begin
         acc(1'b1, `SMC_ADR_CTRL, cv[i]);
         chk(flt, 1'b0);
         tick();
         chk({o_mode, o_fill_en, o_wt_en}, mx[i]);
         acc(1'b0, `SMC_ADR_CTRL, 32'h0);
         chk(rd, cv[i] & 32'he005_002f);
      end
      // Protected mode: whole descriptor lands in the cache
      @(posedge i_clk) dsc <= '{32'h1000_0000, 32'h0000_00ff, 8'h03};
      acc(1'b1, 8'h04, 32'h8);
      req(SMC_STK_WR, 3'h0, 32'h10);
      chk({res.lin, res.limit_flt, res.attr_flt}, {32'h1000_0010, 2'b01});
      req(SMC_STK_RD, 3'h0, 32'hff);
      chk({res.limit_flt, res.attr_flt}, 2'b00);
      req(SMC_STK_RD, 3'h0, 32'h100);
      chk({res.limit_flt, res.attr_flt}, 2'b10);
      @(posedge i_clk) dsc <= '{32'h0, 32'hffff_ffff, 8'h07};
      acc(1'b1, 8'h14, 32'h10);
      req(SMC_WR, 3'h5, 32'hffff_ffff);
      chk({res.lin, res.limit_flt, res.attr_flt}, {32'hffff_ffff, 2'b00});
      @(posedge i_clk) dsc <= '{32'h2000_0000, 32'h0000_ffff, 8'h19};
      acc(1'b1, 8'h00, 32'h18);
      tick();
      chk(o_def32, 1'b1);
      req(SMC_RD, 3'h0, 32'h4);
      chk({res.lin, res.attr_flt}, {32'h2000_0004, 1'b1});
      // A frozen clock enable must drop a selector write
      @(posedge i_clk) i_ce <= 1'b0;
      acc(1'b1, 8'h08, 32'h55);
      @(posedge i_clk) i_ce <= 1'b1;
      acc(1'b0, 8'h08, 32'h0);
      chk(rd, 32'h0);
      wrap_up();
   end

   // Hang guard
   initial begin
      repeat (20000) @(posedge i_clk);
      n_errors++;
      wrap_up();
   end
endmodule : tb_top
